//--- core/pdc_power_down.v
// Function
// R1: power-down bit write enters/leaves low power
// R2: power-down leaves serial path and ready alone
// R3: registers hold contents while powered down
// R4: ready high stays high until fresh result
// R5: pending result readable during power-down
// R6: completed pending read drives ready high
// R7: unread result keeps ready low throughout
// R8: first result 3 periods plus pipeline delay
// R9: host waits for clock restart before wake; the clock here never halts and pdc_host wr does not wait
// R10: clock output runs unless disabled
// R11: no conversion or calibration while down
`timescale 1ns/10ps
`include "pdc_consts.vh"
module pdc_power_down #(
  parameter ODR_PERIOD_CYC = `PDC_ODR_PERIOD_CYC, // output data rate period, cycles
  parameter PIPE_DELAY_CYC = `PDC_PIPE_DELAY_CYC  // pipeline delay, cycles
) (
  input  wire                   clk_i,             // master clock, 40 MHz
  input  wire                   resetn_i,          // async reset, active low
  input  wire                   pd_wr_i,           // comm register write strobe
  input  wire                   power_down_bit_i,  // power-down bit of that write
  input  wire                   clock_out_disable_i, // clock output disable bit
  input  wire                   cal_req_i,         // calibration start request
  input  wire                   result_rd_done_i,  // data register read completed
  input  wire [`PDC_DATA_W-1:0] filter_data_i,     // filter result word
  input  wire                   filter_valid_i,    // filter result strobe
  output reg  [`PDC_DATA_W-1:0] data_reg_o,        // data register contents
  output reg                    result_ready_n_o,  // data-ready, active low
  output reg                    powered_down_o,    // core in low-power state
  output wire                   core_run_o,        // modulator/filter enable
  output reg                    cal_start_o,       // calibration start pulse
  output wire                   clock_output_pin_o // clock output
);
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_DOWN = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;
  // full-width sum first, then cut to the counter width on purpose
  localparam integer WAKE_SUM =
    `PDC_WAKE_ODR_PERIODS * ODR_PERIOD_CYC + PIPE_DELAY_CYC;
  localparam [`PDC_WAKE_CNT_W-1:0] WAKE_CYC = WAKE_SUM[`PDC_WAKE_CNT_W-1:0];

  reg [1:0]                 state;
  reg [1:0]                 next_state;
  reg [`PDC_WAKE_CNT_W-1:0] wake_cnt;
  wire pd_set = pd_wr_i & power_down_bit_i;
  wire pd_clr = pd_wr_i & ~power_down_bit_i;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN:  if (pd_set) next_state = ST_DOWN;                  // [R1]
      ST_DOWN: if (pd_clr) next_state = ST_WAKE;                  // [R1]
      ST_WAKE: begin
        if (pd_set)
          next_state = ST_DOWN;
        else if (wake_cnt == WAKE_CYC - 1'b1)
          next_state = ST_RUN;                                    // [R8]
      end
      default: next_state = ST_RUN;
    endcase
  end

  // modulator and filter halt while down
  assign core_run_o = (state != ST_DOWN);                         // [R11]

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state            <= ST_RUN;
      wake_cnt         <= {`PDC_WAKE_CNT_W{1'b0}};
      data_reg_o       <= {`PDC_DATA_W{1'b0}};
      result_ready_n_o <= `PDC_READY_IDLE;
      powered_down_o   <= 1'b0;
      cal_start_o      <= 1'b0;
    end else begin
      state          <= next_state;
      powered_down_o <= (next_state == ST_DOWN);
      cal_start_o    <= cal_req_i & (state == ST_RUN);            // [R11]
      if (state == ST_WAKE && next_state == ST_WAKE)
        wake_cnt <= wake_cnt + 1'b1;                              // [R8]
      else
        wake_cnt <= {`PDC_WAKE_CNT_W{1'b0}};
      // data register loads while running or as wake ends; held when down
      if (state == ST_WAKE && next_state == ST_RUN) begin
        data_reg_o       <= filter_data_i;                        // [R8]
        result_ready_n_o <= 1'b0;                                 // [R4]
      end else if (state == ST_RUN && filter_valid_i) begin
        data_reg_o       <= filter_data_i;                        // [R3]
        result_ready_n_o <= 1'b0;
      end else if (result_rd_done_i) begin
        // read ends the pending flag even while down; entry leaves it alone
        result_ready_n_o <= 1'b1;                                 // [R5] [R6] [R2] [R7]
      end
    end
  end

  pdc_clk_gate u_clk_gate (
    .clk_i             (clk_i),
    .resetn_i          (resetn_i),
    .clock_out_disable (clock_out_disable_i),
    .clock_output_pin  (clock_output_pin_o)
  );
endmodule

//--- core/pdc_consts.vh
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
// pipeline delay in master clock periods
`define PDC_PIPE_DELAY_CYC   2000
// output data rate periods before first result after wake
`define PDC_WAKE_ODR_PERIODS 3
// default output data rate period in master clock cycles
`define PDC_ODR_PERIOD_CYC   20000
`define PDC_ODR_CNT_W        16
`define PDC_WAKE_CNT_W       20
`define PDC_DATA_W           16
// idle state of the active-low ready line
`define PDC_READY_IDLE       1'b1
`endif

//--- core/pdc_clk_gate.v
`timescale 1ns/10ps
// clock output gate; free-running divider stays alive in power-down
module pdc_clk_gate (
  input  wire clk_i,             // master clock
  input  wire resetn_i,          // async reset, active low
  input  wire clock_out_disable, // 1 stops clock output
  output reg  clock_output_pin   // divided clock output
);
  reg div;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div              <= 1'b0;
      clock_output_pin <= 1'b0;
    end else begin
      div              <= ~div;
      // power-down is deliberately not an input here
      clock_output_pin <= clock_out_disable ? 1'b0 : div; // [R10]
    end
  end
endmodule

//--- sim/pdc_host.sv
`timescale 1ns/10ps
module pdc_host (
  input  wire clk_i,    // master clock
  output reg  pd_wr_o,  // comm register write
  output reg  pd_bit_o, // power-down bit
  output reg  rd_done_o // data register read done
);
  initial {pd_wr_o, pd_bit_o, rd_done_o} = 3'h0;
  // clock never halts here, so a wake needs no restart wait
  task wr(input logic b);
    @(posedge clk_i) #2 {pd_wr_o, pd_bit_o} = {1'b1, b};
    @(posedge clk_i) #2 {pd_wr_o, pd_bit_o} = {1'b0, ~b};
  endtask
  task rd; // pending word fetched even while down
    @(posedge clk_i) #2 rd_done_o = 1'b1;
    @(posedge clk_i) #2 rd_done_o = 1'b0;
  endtask
endmodule

//--- sim/pdc_power_down_asserts.sv
`timescale 1ns/10ps
`include "pdc_consts.vh"
module pdc_pd_chk #(parameter ODR_PERIOD_CYC = 10, parameter PIPE_DELAY_CYC = 5) (
  input wire logic clk_i, resetn_i, pd_wr_i, power_down_bit_i, clock_out_disable_i,
  input wire logic result_rd_done_i, result_ready_n_o, powered_down_o, core_run_o,
  input wire logic cal_start_o, clock_output_pin_o,
  input wire logic [`PDC_DATA_W-1:0] data_reg_o
);
  localparam int WAKE_LO = 3 * ODR_PERIOD_CYC + PIPE_DELAY_CYC;
  localparam int WAKE_HI = WAKE_LO + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_sleep; pd_wr_i && power_down_bit_i; endsequence
  sequence s_wake; pd_wr_i && !power_down_bit_i && powered_down_o; endsequence
  a_enter_down: assert property (s_sleep |=> powered_down_o) else $error("no sleep");
  a_leave_down: assert property (pd_wr_i && !power_down_bit_i |=> !powered_down_o)
    else $error("no leave");
  a_ready_kept: assert property (s_sleep ##0 !powered_down_o && !result_rd_done_i
    |=> $stable(result_ready_n_o)) else $error("ready moved");
  a_data_held: assert property (powered_down_o |=> $stable(data_reg_o))
    else $error("data moved");
  a_high_held: assert property (powered_down_o && result_ready_n_o |=> result_ready_n_o)
    else $error("ready fell");
  a_wake_quiet: assert property (s_wake ##0 result_ready_n_o |=> result_ready_n_o[*8])
    else $error("early ready");
  a_read_clear: assert property (powered_down_o && result_rd_done_i |=> result_ready_n_o)
    else $error("ready stuck");
  a_low_held: assert property (powered_down_o && !result_rd_done_i && !result_ready_n_o
    |=> !result_ready_n_o) else $error("ready rose");
  a_wake_time: assert property (s_wake |-> ##[WAKE_LO:WAKE_HI] !result_ready_n_o)
    else $error("late result");
  a_clock_runs: assert property (!clock_out_disable_i[*3] |=>
    clock_output_pin_o != $past(clock_output_pin_o)) else $error("clock stopped");
  a_core_idle: assert property (powered_down_o |-> !core_run_o) else $error("core ran");
  a_no_cal: assert property (powered_down_o |=> !cal_start_o) else $error("cal ran");
endmodule
bind pdc_power_down pdc_pd_chk #(.ODR_PERIOD_CYC(ODR_PERIOD_CYC),
  .PIPE_DELAY_CYC(PIPE_DELAY_CYC)) i_chk (.*);

//--- sim/tb_top.sv
`timescale 1ns/10ps
`include "pdc_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk_i = 0, resetn_i = 0, dis = 0, cal = 0, fv = 0;
  logic [`PDC_DATA_W-1:0] fd = 16'h0000, v, d, q[$];
  logic c1;
  wire pd_wr, pd_bit, rd_done, rdy_n, down, run, cs, ck;
  wire [`PDC_DATA_W-1:0] data;
  int err_total = 0, n_compared = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  pdc_host i_host (.clk_i(clk_i), .pd_wr_o(pd_wr), .pd_bit_o(pd_bit), .rd_done_o(rd_done));
  pdc_power_down #(.ODR_PERIOD_CYC(10), .PIPE_DELAY_CYC(5)) i_dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .pd_wr_i(pd_wr), .power_down_bit_i(pd_bit),
    .clock_out_disable_i(dis), .cal_req_i(cal), .result_rd_done_i(rd_done),
    .filter_data_i(fd), .filter_valid_i(fv), .data_reg_o(data), .result_ready_n_o(rdy_n),
    .powered_down_o(down), .core_run_o(run), .cal_start_o(cs), .clock_output_pin_o(ck));
  task automatic tick(int n); repeat (n) @(posedge clk_i); #2; endtask
  task final_report;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(negedge rdy_n) if (resetn_i) begin
    #1 d = q.pop_front();
    `CHK("data_reg_o", d, data)
  end
  always @(posedge clk_i) if (++cyc == 1000) begin err_total++; final_report; end
  initial begin
    void'($urandom(32'h4323));
    tick(8); resetn_i = 1; tick(2);
    for (int k = 0; k < 2; k++) begin
      i_host.rd(); tick(1);
      v = $urandom; fd = v; q.push_back(v); fv = 1; cal = 1; dis = k[0];
      tick(1); fv = 0; cal = 0;
      `CHK("cal_start_o", 1'b1, cs)
      tick(2);
      i_host.wr(1'b1);
      `CHK("ready_n", 1'b0, rdy_n)
      `CHK("down", 1'b1, down)
      fd = $urandom; fv = 1; cal = 1; tick(4); fv = 0; cal = 0;
      `CHK("data_reg_o", v, data)
      `CHK("cal_start_o", 1'b0, cs)
      `CHK("core_run_o", 1'b0, run)
      c1 = ck; tick(1);
      `CHK("clock_output_pin_o", (k != 0) ? 1'b0 : ~c1, ck)
      if (k == 0) begin i_host.rd(); tick(1); `CHK("ready_n", 1'b1, rdy_n) end
      else begin tick(20); `CHK("ready_n", 1'b0, rdy_n) end
      fd = $urandom; if (k == 0) q.push_back(fd);
      i_host.wr(1'b0); tick(40);
      `CHK("data_reg_o", fd, data)
    end
    final_report;
  end
endmodule
